// ===== design/match_engine_register_bank.sv
// Register file of the match engine: control, status, key, result queue, rule memory.
// Assumes the bus bridge hands over register traffic synchronous to i_clk_sys.
//
// Function
// - Write strobe carries word address, value, lane mask
// - Mask bit n enables byte n of value
// - Read request answered by read-valid with value
// - One shared address; no simultaneous read and write
// - Bridge synchronises host traffic into engine domain
// - Offset 0x0000 bit 0 drives engine reset_n
// - Offset 0x0004 returns full engine version
// - Offset 0x0008 low nibble gives init result
// - Offset 0x000C write pulses start, read busy
// - Offset 0x0010 low half sets rule width
// - Offset 0x0014 sets number of rules loaded
// - Key upper at 0x0020, lower at 0x0024
// - Write 0x0028 pulses search go one cycle
// - Finished search result pushed into result queue
// - Offset 0x0040 reads empty, write flushes queue
// - Offset 0x0044 returns queue output when nonempty
// - Rule memory dual-port: host port, engine port
// - Engine fetches rule by address and request
// - Engine fetch data valid one cycle later
// - Host reaches rule memory from offset 0x4000
`default_nettype none

module match_engine_register_bank
    import match_engine_pkg::*;
(
    input wire logic i_clk_sys,                         // Engine clock, 100 MHz
    input wire logic i_reset,                           // Asynchronous, active high
    input wire logic i_clk_en,                          // Freezes all state when low
    input wire reg_req_s i_reg_req,                     // Register access from bridge
    output logic o_reg_read_valid,                      // Read answer strobe
    output logic [DATA_W-1:0] o_reg_read_value,         // Read answer data
    output logic o_engine_reset_n,                      // Engine reset, active low
    input wire logic [DATA_W-1:0] i_engine_version_value, // Engine version
    input wire logic [STATUS_CODE_W-1:0] i_init_result_code, // Init result code
    input wire logic i_init_in_progress,                // Init busy flag
    output logic o_init_start_pulse,                    // Init start, one cycle
    output logic [RULE_WIDTH_W-1:0] o_rule_width_value, // Bits per rule
    output logic [DATA_W-1:0] o_rule_total_value,       // Rules to load
    output logic [2*DATA_W-1:0] o_search_key,           // Held search key
    output logic o_search_go_pulse,                     // Search start, one cycle
    input wire logic i_result_push,                     // Engine result ready
    input wire logic [DATA_W-1:0] i_result_value,       // Engine result word
    output logic o_result_queue_empty,                  // Queue empty flag
    input wire logic [DATA_W-1:0] i_rule_fetch_addr,    // Engine rule address
    input wire logic i_rule_fetch_request,              // Engine rule fetch
    output logic o_rule_fetch_valid,                    // Fetch data valid
    output logic [RULE_W-1:0] o_rule_fetch_value        // Fetched rule data
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] W_ENGINE_RESET = OFF_ENGINE_RESET[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_VERSION = OFF_VERSION[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_INIT_STATUS = OFF_INIT_STATUS[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_INIT_START = OFF_INIT_START[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_RULE_WIDTH = OFF_RULE_WIDTH[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_RULE_TOTAL = OFF_RULE_TOTAL[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_KEY_UPPER = OFF_KEY_UPPER[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_KEY_LOWER = OFF_KEY_LOWER[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_SEARCH_GO = OFF_SEARCH_GO[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_QUEUE_STATE = OFF_QUEUE_STATE[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_QUEUE_VALUE = OFF_QUEUE_VALUE[ADDR_W+1:2];
    localparam logic [ADDR_W-1:0] W_RULE_WINDOW = OFF_RULE_WINDOW[ADDR_W+1:2];

    logic wr_en;                 // Qualified write this cycle
    logic rd_en;                 // Qualified read this cycle
    logic in_window;             // Address falls in rule memory window
    logic [RULE_AW-1:0] win_idx; // Rule memory index from host address
    logic [DATA_W-1:0] lane_bits; // Byte mask widened to bits

    // Inputs are already in this clock domain; the bridge did the crossing
    assign wr_en = i_clk_en && i_reg_req.wr;
    // A read colliding with a write is dropped; the write goes ahead
    assign rd_en = i_clk_en && i_reg_req.rd && !i_reg_req.wr;
    assign in_window = (i_reg_req.addr >= W_RULE_WINDOW)
        && (i_reg_req.addr < W_RULE_WINDOW + ADDR_W'(RULE_DEPTH));
    assign win_idx = RULE_AW'(i_reg_req.addr - W_RULE_WINDOW);

    // ------------------------------------------------------------------
    // Byte lane expansion
    // ------------------------------------------------------------------
    genvar lane;
    generate
        for (lane = 0; lane < LANE_W; lane++)
        begin : g_lane
            // Each mask bit gates its own byte of the write value
            assign lane_bits[lane*8 +: 8] = {8{i_reg_req.mask[lane]}};
        end
    endgenerate

    // Merge write value into an old word under the lane mask
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v);
        merge = (old_v & ~lane_bits) | (i_reg_req.data & lane_bits);
    endfunction

    logic bit0_set;  // Bit 0 written as one with lane 0 enabled
    assign bit0_set = i_reg_req.mask[0] && i_reg_req.data[CTRL_BIT];

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    logic engine_reset_n_r;                  // Engine reset level
    logic [RULE_WIDTH_W-1:0] rule_width_r;   // Rule width field
    logic [DATA_W-1:0] rule_total_r;         // Rule count
    logic [2*DATA_W-1:0] search_key_r;       // Search key, both halves

    // Engine reset bit, lane 0 only
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            engine_reset_n_r <= RST_ENGINE_RESET_N;
        end
        else if (wr_en && i_reg_req.addr == W_ENGINE_RESET && i_reg_req.mask[0])
        begin
            engine_reset_n_r <= i_reg_req.data[CTRL_BIT];
        end
    end

    // Rule width, low half of the word
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            rule_width_r <= RST_RULE_WIDTH;
        end
        else if (wr_en && i_reg_req.addr == W_RULE_WIDTH)
        begin
            rule_width_r <= RULE_WIDTH_W'(merge({16'h0000, rule_width_r}));
        end
    end

    // Rule count, full word
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            rule_total_r <= RST_RULE_TOTAL;
        end
        else if (wr_en && i_reg_req.addr == W_RULE_TOTAL)
        begin
            rule_total_r <= merge(rule_total_r);
        end
    end

    // Search key halves, each write touches only its own half
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            search_key_r <= RST_SEARCH_KEY;
        end
        else if (wr_en && i_reg_req.addr == W_KEY_UPPER)
        begin
            search_key_r[2*DATA_W-1:DATA_W] <= merge(search_key_r[2*DATA_W-1:DATA_W]);
        end
        else if (wr_en && i_reg_req.addr == W_KEY_LOWER)
        begin
            search_key_r[DATA_W-1:0] <= merge(search_key_r[DATA_W-1:0]);
        end
    end

    // ------------------------------------------------------------------
    // Command pulses
    // ------------------------------------------------------------------
    logic init_start_r; // Init start pulse
    logic search_go_r;  // Search go pulse

    // One-cycle pulses; a frozen clock holds them, an enabled edge clears them
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            init_start_r <= 1'b0;
            search_go_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            init_start_r <= wr_en && i_reg_req.addr == W_INIT_START && bit0_set;
            search_go_r <= wr_en && i_reg_req.addr == W_SEARCH_GO && bit0_set;
        end
    end

    // ------------------------------------------------------------------
    // Result queue
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] queue_mem [QUEUE_DEPTH]; // Queue storage
    logic [QUEUE_AW:0] wr_ptr_r;                // Push pointer, extra wrap bit
    logic [QUEUE_AW:0] rd_ptr_r;                // Pop pointer, extra wrap bit
    logic queue_empty;                          // No entries held
    logic queue_full;                           // All entries held
    logic queue_flush;                          // Discard everything
    logic queue_pop;                            // Remove head entry
    logic queue_push;                           // Store engine result
    logic [DATA_W-1:0] result_queue_output;     // Head entry

    assign queue_empty = (wr_ptr_r == rd_ptr_r);
    assign queue_full = (wr_ptr_r[QUEUE_AW] != rd_ptr_r[QUEUE_AW])
        && (wr_ptr_r[QUEUE_AW-1:0] == rd_ptr_r[QUEUE_AW-1:0]);
    assign queue_flush = wr_en && i_reg_req.addr == W_QUEUE_STATE && bit0_set;
    assign queue_pop = rd_en && i_reg_req.addr == W_QUEUE_VALUE && !queue_empty;
    // A result arriving while full is lost; the engine has no stall input
    assign queue_push = i_clk_en && i_result_push && !queue_full;
    assign result_queue_output = queue_mem[rd_ptr_r[QUEUE_AW-1:0]];

    // Storage write, no reset needed
    always_ff @(posedge i_clk_sys)
    begin
        if (queue_push)
        begin
            queue_mem[wr_ptr_r[QUEUE_AW-1:0]] <= i_result_value;
        end
    end

    // Push pointer; a push in the flush cycle survives the flush
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            wr_ptr_r <= '0;
        end
        else if (queue_push)
        begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    // Pop pointer; flush jumps to the push pointer, keeping a same-cycle push
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            rd_ptr_r <= '0;
        end
        else if (queue_flush)
        begin
            rd_ptr_r <= wr_ptr_r;
        end
        else if (queue_pop)
        begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Rule memory, two ports
    // ------------------------------------------------------------------
    logic [RULE_W-1:0] rule_mem [RULE_DEPTH]; // Rule table
    logic [RULE_W-1:0] host_rule_r;           // Host port read data
    logic [RULE_W-1:0] fetch_value_r;         // Engine port read data
    logic fetch_valid_r;                      // Engine port valid

    // Host port: write and read through the window
    always_ff @(posedge i_clk_sys)
    begin
        if (wr_en && in_window)
        begin
            rule_mem[win_idx] <= RULE_W'(merge({23'h0, rule_mem[win_idx]}));
        end
        if (rd_en && in_window)
        begin
            host_rule_r <= rule_mem[win_idx];
        end
    end

    // Engine port: read only, data one cycle after the request
    always_ff @(posedge i_clk_sys)
    begin
        if (i_clk_en && i_rule_fetch_request)
        begin
            fetch_value_r <= rule_mem[i_rule_fetch_addr[RULE_AW-1:0]];
        end
    end

    // Engine port valid strobe
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            fetch_valid_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            fetch_valid_r <= i_rule_fetch_request;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic read_valid_r;              // Read answer strobe
    logic [DATA_W-1:0] read_value_r; // Read answer data for registers
    logic read_window_r;             // Answer comes from rule memory
    logic [DATA_W-1:0] read_mux;     // Register read selection

    // Register read selection; write-only and unmapped words read zero
    always_comb
    begin
        read_mux = '0;
        case (i_reg_req.addr)
            W_VERSION: read_mux = i_engine_version_value;
            W_INIT_STATUS: read_mux = {28'h0000000, i_init_result_code};
            W_INIT_START: read_mux = {31'h0, i_init_in_progress};
            W_QUEUE_STATE: read_mux = {31'h0, queue_empty};
            W_QUEUE_VALUE: read_mux = queue_empty ? '0 : result_queue_output;
            default: read_mux = '0;
        endcase
    end

    // Capture the answer one cycle after the request
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            read_valid_r <= 1'b0;
            read_value_r <= '0;
            read_window_r <= 1'b0;
        end
        else if (i_clk_en)
        begin
            read_valid_r <= rd_en;
            if (rd_en)
            begin
                read_value_r <= read_mux;
                read_window_r <= in_window;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_reg_read_valid = read_valid_r;
    assign o_reg_read_value = read_window_r ? {23'h0, host_rule_r} : read_value_r;
    assign o_engine_reset_n = engine_reset_n_r;
    assign o_init_start_pulse = init_start_r;
    assign o_rule_width_value = rule_width_r;
    assign o_rule_total_value = rule_total_r;
    assign o_search_key = search_key_r;
    assign o_search_go_pulse = search_go_r;
    assign o_result_queue_empty = queue_empty;
    assign o_rule_fetch_valid = fetch_valid_r;
    assign o_rule_fetch_value = fetch_value_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    sequence host_write_s(logic [ADDR_W-1:0] a);
        i_clk_en && i_reg_req.wr && i_reg_req.addr == a;
    endsequence

    sequence host_read_s(logic [ADDR_W-1:0] a);
        i_clk_en && i_reg_req.rd && !i_reg_req.wr && i_reg_req.addr == a;
    endsequence

    reset_bit_follows_a: assert property (
        host_write_s(W_ENGINE_RESET) and i_reg_req.mask[0]
        |=> o_engine_reset_n == $past(i_reg_req.data[0]))
        else $error("engine reset bit not taken from write");

    start_pulse_once_a: assert property (
        (host_write_s(W_INIT_START) and bit0_set) ##1 (i_clk_en && !i_reg_req.wr)
        |-> o_init_start_pulse ##1 !o_init_start_pulse)
        else $error("init start pulse not exactly one cycle");

    search_go_once_a: assert property (
        (host_write_s(W_SEARCH_GO) and bit0_set) ##1 (i_clk_en && !i_reg_req.wr)
        |-> o_search_go_pulse ##1 !o_search_go_pulse)
        else $error("search go pulse not exactly one cycle");

    key_upper_only_a: assert property (
        host_write_s(W_KEY_UPPER) and i_reg_req.mask == 4'hf
        |=> o_search_key[63:32] == $past(i_reg_req.data)
            && $stable(o_search_key[31:0]))
        else $error("upper key write wrong");

    version_read_a: assert property (
        host_read_s(W_VERSION)
        |=> o_reg_read_valid && o_reg_read_value == $past(i_engine_version_value))
        else $error("version read wrong");

    rw_collide_a: assert property (
        i_clk_en && i_reg_req.wr && i_reg_req.rd |=> !o_reg_read_valid)
        else $error("read answered during write");

    fetch_latency_a: assert property (
        i_clk_en && i_rule_fetch_request
        |=> o_rule_fetch_valid ##0 o_rule_fetch_value
            == $past(rule_mem[i_rule_fetch_addr[RULE_AW-1:0]]))
        else $error("rule fetch not valid one cycle later");

    flush_empties_a: assert property (
        host_write_s(W_QUEUE_STATE) and bit0_set and !i_result_push
        |=> o_result_queue_empty)
        else $error("flush left queue entries");

    pop_one_a: assert property (
        host_read_s(W_QUEUE_VALUE) and !queue_empty and !i_result_push
        |=> o_reg_read_value == $past(result_queue_output)
            && wr_ptr_r - rd_ptr_r == $past(wr_ptr_r - rd_ptr_r) - 1'b1)
        else $error("result read did not pop one entry");

endmodule // match_engine_register_bank

`default_nettype wire

// ===== pkg/match_engine_pkg.sv
// Constants, field layouts and carrier types for the match engine register bank.
// Assumes one engine clock; the host bus bridge delivers requests already in that domain.
`default_nettype none

package match_engine_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 14;          // Word address, 32-bit units
    localparam int DATA_W = 32;          // Register data width
    localparam int LANE_W = 4;           // One mask bit per byte
    localparam int RULE_W = 9;           // Rule memory data width
    localparam int RULE_DEPTH = 1024;    // Rule memory entries
    localparam int RULE_AW = 10;         // Rule memory index width
    localparam int QUEUE_DEPTH = 16;     // Result queue entries
    localparam int QUEUE_AW = 4;         // Result queue index width

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] OFF_ENGINE_RESET = 16'h0000;
    localparam logic [15:0] OFF_VERSION = 16'h0004;
    localparam logic [15:0] OFF_INIT_STATUS = 16'h0008;
    localparam logic [15:0] OFF_INIT_START = 16'h000c;
    localparam logic [15:0] OFF_RULE_WIDTH = 16'h0010;
    localparam logic [15:0] OFF_RULE_TOTAL = 16'h0014;
    localparam logic [15:0] OFF_KEY_UPPER = 16'h0020;
    localparam logic [15:0] OFF_KEY_LOWER = 16'h0024;
    localparam logic [15:0] OFF_SEARCH_GO = 16'h0028;
    localparam logic [15:0] OFF_QUEUE_STATE = 16'h0040;
    localparam logic [15:0] OFF_QUEUE_VALUE = 16'h0044;
    localparam logic [15:0] OFF_RULE_WINDOW = 16'h4000;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_BIT = 0;                     // Control or flag bit
    localparam int STATUS_CODE_W = 4;                // Result code width
    localparam int RULE_WIDTH_W = 16;                // Rule width field
    localparam logic RST_ENGINE_RESET_N = 1'b0;      // Engine held in reset
    localparam logic [15:0] RST_RULE_WIDTH = 16'h0000;
    localparam logic [31:0] RST_RULE_TOTAL = 32'h0000_0000;
    localparam logic [63:0] RST_SEARCH_KEY = 64'h0000_0000_0000_0000;
    localparam int READ_LATENCY = 1;                 // Cycles request to valid

    // ------------------------------------------------------------------
    // Carrier for one register access
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;                      // Write strobe
        logic rd;                      // Read request
        logic [ADDR_W-1:0] addr;       // Word address
        logic [DATA_W-1:0] data;       // Write value
        logic [LANE_W-1:0] mask;       // Byte lane mask
    } reg_req_s;

endpackage

`default_nettype wire

// ===== sim/engine_model.sv
// Behavioural match engine facing the register bank's engine side.
// Assumes the bank's clock and reset; it fetches rules 0 to 3 at each init.
`default_nettype none

module engine_model
    import match_engine_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_init_start_pulse,
    input wire logic i_search_go_pulse,
    input wire logic [2*DATA_W-1:0] i_search_key,
    input wire logic i_rule_fetch_valid,
    input wire logic [RULE_W-1:0] i_rule_fetch_value,
    output logic o_init_in_progress,
    output logic [3:0] o_init_result_code,
    output logic [DATA_W-1:0] o_rule_fetch_addr,
    output logic o_rule_fetch_request,
    output logic o_result_push,
    output logic [DATA_W-1:0] o_result_value,
    output logic [11:0] o_fetch_sum
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] step_r; // Cycles since init began

    // Busy for eight cycles, fetch four rules, sum them; echo each search
    always_ff @(posedge i_clk_sys or posedge i_reset)
    begin
        if (i_reset)
        begin
            o_init_in_progress <= 1'b0;
            o_init_result_code <= 4'h0;
            o_fetch_sum <= 12'h000;
            step_r <= 3'h0;
            o_result_push <= 1'b0;
        end
        else
        begin
            o_init_in_progress <= i_init_start_pulse || (o_init_in_progress && step_r != 3'h7);
            step_r <= o_init_in_progress ? step_r + 3'h1 : 3'h0;
            if (i_rule_fetch_valid)
                o_fetch_sum <= o_fetch_sum + 12'(i_rule_fetch_value);
            if (step_r == 3'h7)
                o_init_result_code <= 4'h1;
            o_result_push <= i_search_go_pulse;
        end
    end

    // One fetch a cycle while the first four steps run
    assign o_rule_fetch_request = o_init_in_progress && step_r < 3'h4;
    assign o_rule_fetch_addr = 32'(step_r);

    // Result word is the two key halves folded together
    always_ff @(posedge i_clk_sys)
        o_result_value <= i_search_key[63:32] ^ i_search_key[31:0];
endmodule // engine_model

`default_nettype wire

// ===== sim/match_engine_register_bank_test.sv
// Self-checking bench for the match engine register bank.
// Assumes the engine model on the far side and a 100 MHz clock.
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module match_engine_register_bank_test
    import match_engine_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] VERSION_ID = 32'h0000_0a51; // Arbitrary value
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    reg_req_s req = '0;
    logic rd_valid, rst_n, init_go, busy, go, push, empty, f_req, f_valid;
    logic [3:0] code;
    logic [15:0] width;
    logic [31:0] rd_value, total, f_addr, result, v;
    logic [63:0] key;
    logic [8:0] f_value;
    logic [11:0] sum, exp_sum;
    int errors = 0;
    int checks_done = 0;
    logic en = 1'b1; // Clock enable into the bank

    always #5 i_clk_sys = ~i_clk_sys;

    match_engine_register_bank uut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_clk_en(en),
        .i_reg_req(req), .o_reg_read_valid(rd_valid), .o_reg_read_value(rd_value),
        .o_engine_reset_n(rst_n), .i_engine_version_value(VERSION_ID),
        .i_init_result_code(code), .i_init_in_progress(busy), .o_init_start_pulse(init_go),
        .o_rule_width_value(width), .o_rule_total_value(total), .o_search_key(key),
        .o_search_go_pulse(go), .i_result_push(push), .i_result_value(result),
        .o_result_queue_empty(empty), .i_rule_fetch_addr(f_addr),
        .i_rule_fetch_request(f_req), .o_rule_fetch_valid(f_valid), .o_rule_fetch_value(f_value));
    engine_model model (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_init_start_pulse(init_go),
        .i_search_go_pulse(go), .i_search_key(key), .i_rule_fetch_valid(f_valid),
        .i_rule_fetch_value(f_value), .o_init_in_progress(busy), .o_init_result_code(code),
        .o_rule_fetch_addr(f_addr), .o_rule_fetch_request(f_req), .o_result_push(push),
        .o_result_value(result), .o_fetch_sum(sum));

    // Register write: strobe held for one edge, then released
    task automatic wr(input logic [15:0] off, input logic [31:0] val, input logic [3:0] m);
        @(negedge i_clk_sys);
        req = '{wr: 1'b1, rd: 1'b0, addr: off[15:2], data: val, mask: m};
        @(negedge i_clk_sys);
        req.wr = 1'b0;
    endtask

    // Register read: request for one edge, then wait for the answer
    task automatic rd(input logic [15:0] off, output logic [31:0] val);
        int n;
        @(negedge i_clk_sys);
        req.rd = 1'b1;
        req.addr = off[15:2];
        @(negedge i_clk_sys);
        req.rd = 1'b0;
        for (n = 0; n < 4 && rd_valid !== 1'b1; n++)
            @(negedge i_clk_sys);
        `CHK(rd_valid, 1'b1)
        val = rd_value;
    endtask

    task automatic rdc(input logic [15:0] off, input logic [31:0] exp);
        logic [31:0] got;
        rd(off, got);
        `CHK(got, exp)
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        int i;
        logic [8:0] rv;
        exp_sum = 12'h000;
        repeat (10) @(negedge i_clk_sys);
        i_reset = 1'b0;
        `CHK(rst_n, 1'b0)
        `CHK(empty, 1'b1)
        rdc(16'h0004, VERSION_ID);
        wr(16'h0000, 32'h1, 4'h0);
        `CHK(rst_n, 1'b0)
        wr(16'h0000, 32'h1, 4'h1);
        `CHK(rst_n, 1'b1)
        wr(16'h0010, 32'habcd_1234, 4'h3);
        `CHK(width, 16'h1234)
        wr(16'h0014, 32'hffff_ffff, 4'hf);
        wr(16'h0014, 32'h0, 4'h5);
        `CHK(total, 32'hff00_ff00)
        // Load four rules through the window, reading each back
        for (i = 0; i < 4; i++)
        begin
            rv = 9'(9'h1a5 + 9'(61 * i));
            exp_sum = exp_sum + 12'(rv);
            wr(16'h4000 + 16'(4 * i), 32'(rv), 4'h3);
            rdc(16'h4000 + 16'(4 * i), 32'(rv));
        end
        wr(16'h000c, 32'h1, 4'h1);
        `CHK(init_go, 1'b1)
        @(negedge i_clk_sys);
        `CHK(init_go, 1'b0)
        rd(16'h000c, v);
        `CHK(v[0], 1'b1)
        for (i = 0; i < 20 && v[0] === 1'b1; i++)
            rd(16'h000c, v);
        `CHK(v[0], 1'b0)
        rd(16'h0008, v);
        `CHK(v[3:0], 4'h1)
        `CHK(sum, exp_sum)
        // Two searches; the second rewrites only the lower key half
        for (i = 0; i < 2; i++)
        begin
            wr(16'h0024, 32'h3322_1100 + 32'(i), 4'hf);
            if (i == 0)
                wr(16'h0020, 32'h7766_5544, 4'hf);
            `CHK(key, {32'h7766_5544, 32'h3322_1100 + 32'(i)})
            wr(16'h0028, 32'h1, 4'h1);
            `CHK(go, 1'b1)
            @(negedge i_clk_sys);
            `CHK(go, 1'b0)
        end
        rd(16'h0040, v);
        `CHK(v[0], 1'b0)
        for (i = 0; i < 2; i++)
            rdc(16'h0044, 32'h4444_4444 ^ 32'(i));
        `CHK(empty, 1'b1)
        rdc(16'h0044, 32'h0);
        wr(16'h0028, 32'h1, 4'h1);
        wr(16'h0028, 32'h1, 4'h1);
        repeat (3) @(negedge i_clk_sys);
        `CHK(empty, 1'b0)
        wr(16'h0040, 32'h1, 4'h1);
        `CHK(empty, 1'b1)
        // Access list changed: rewrite rule 0, then initialise again
        wr(16'h4000, 32'h0, 4'h3);
        wr(16'h000c, 32'h1, 4'h1);
        repeat (12) @(negedge i_clk_sys);
        rdc(16'h000c, 32'h0);
        `CHK(sum, 12'(2 * exp_sum - 12'h1a5))
        // Read and write together: the write lands, the read is dropped
        @(negedge i_clk_sys);
        req = '{wr: 1'b1, rd: 1'b1, addr: 14'h0004, data: 32'h55, mask: 4'hf};
        @(negedge i_clk_sys);
        req = '0;
        `CHK(rd_valid, 1'b0)
        `CHK(width, 16'h0055)
        // Clock enable low: the write is not taken
        en = 1'b0;
        wr(16'h0010, 32'h0, 4'hf);
        `CHK(width, 16'h0055)
        en = 1'b1;
        summarize();
    end

    // Watchdog well beyond the hundred or so cycles the run needs
    initial
    begin
        #50us;
        errors++;
        summarize();
    end
endmodule // match_engine_register_bank_test

`default_nettype wire
